// >>> include/pbc_pkg.sv
/*
 * Shared constants for the bridge control/status register bank:
 * offsets, field positions, reset values, bus states, byte-lane mask.
 * Assumes a 32-bit register port with byte addresses and byte enables.
 */
package pbc_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int unsigned PBC_AW       = 14;
    localparam int unsigned PBC_DW       = 32;
    localparam int unsigned PBC_MBX_NUM  = 8;
    localparam int unsigned PBC_MBX_IW   = 3;
    localparam int unsigned PBC_ATT_NUM  = 64;
    localparam int unsigned PBC_ATT_IW   = 6;
    localparam int unsigned PBC_VEC_W    = 6;

    // ------------------------------------------------------------
    // Sub-regions (address bits 13:12)
    // ------------------------------------------------------------
    localparam logic [1:0] PBC_REG_HOST  = 2'h0;
    localparam logic [1:0] PBC_REG_ATT   = 2'h1;
    localparam logic [1:0] PBC_REG_RSVD  = 2'h2;
    localparam logic [1:0] PBC_REG_LOCAL = 2'h3;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [13:0] PBC_HOST_IRQ_STATUS  = 14'h0040;
    localparam logic [13:0] PBC_HOST_IRQ_ENABLE  = 14'h0050;
    localparam logic [13:0] PBC_H2L_MBX_WRITE    = 14'h0800;
    localparam logic [13:0] PBC_L2H_MBX_VIEW     = 14'h0900;
    localparam logic [13:0] PBC_ATT_BASE         = 14'h1000;
    localparam logic [13:0] PBC_LOCAL_IRQ_STATUS = 14'h3060;
    localparam logic [13:0] PBC_LOCAL_IRQ_ENABLE = 14'h3070;
    localparam logic [13:0] PBC_L2H_MBX_WRITE    = 14'h3A00;
    localparam logic [13:0] PBC_H2L_MBX_VIEW     = 14'h3B00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned PBC_HOST_LVL_BIT = 7;
    localparam int unsigned PBC_HOST_VEC_LSB = 8;
    localparam int unsigned PBC_HOST_MB_LSB  = 16;
    localparam int unsigned PBC_LOCAL_MB_LSB = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] PBC_RST_WORD = 32'h0000_0000;
    localparam logic [7:0]  PBC_RST_MB   = 8'h00;
    localparam logic [5:0]  PBC_RST_VEC  = 6'h00;

    typedef enum logic [0:0] {
        PBC_BUS_IDLE  = 1'b0,
        PBC_BUS_RDATA = 1'b1
    } pbc_bus_e;

    // Byte enables to a 32-bit lane mask
    function automatic logic [31:0] pbc_be_mask(input logic [3:0] be);
        pbc_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : pbc_be_mask

    // Word lies within a 32-byte, eight-word window at base
    function automatic logic pbc_in_mbx(input logic [13:0] a, input logic [13:0] base);
        pbc_in_mbx = (a[13:5] == base[13:5]);
    endfunction : pbc_in_mbx

endpackage : pbc_pkg

// >>> verilog/pbc_mbx_bank.sv
/*
 * Eight 32-bit mailbox words with a byte-masked write port and
 * a combinational read port.
 * Assumes write strobes come from logic on the same clock.
 */
`timescale 1ns/10ps

module pbc_mbx_bank
    import pbc_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Write port
    input  wire logic                  wr_en,
    input  wire logic [PBC_MBX_IW-1:0] wr_idx,
    input  wire logic [PBC_DW-1:0]     wr_data,
    input  wire logic [PBC_DW-1:0]     wr_mask,
    // Read port
    input  wire logic [PBC_MBX_IW-1:0] rd_idx,
    output logic      [PBC_DW-1:0]     rd_data
);
    import pbc_pkg::*;

    typedef struct packed {
        logic [PBC_MBX_NUM-1:0][PBC_DW-1:0] word;
    } pbc_mbx_s;

    pbc_mbx_s st;
    pbc_mbx_s next_st;

    always_comb
    begin
        next_st = st;
        if (wr_en)
        begin
            next_st.word[wr_idx] = (st.word[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign rd_data = st.word[rd_idx];

endmodule : pbc_mbx_bank

// >>> verilog/pbc_att_table.sv
/*
 * Address translation table: 64 words, byte-masked bus write, bus read,
 * and a registered lookup port for the translation logic.
 * Assumes all ports are driven from the same clock.
 */
`timescale 1ns/10ps

module pbc_att_table
    import pbc_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Bus side
    input  wire logic                  wr_en,
    input  wire logic [PBC_ATT_IW-1:0] wr_idx,
    input  wire logic [PBC_DW-1:0]     wr_data,
    input  wire logic [PBC_DW-1:0]     wr_mask,
    input  wire logic [PBC_ATT_IW-1:0] rd_idx,
    output logic      [PBC_DW-1:0]     rd_data,
    // Translation side
    input  wire logic [PBC_ATT_IW-1:0] look_idx,
    output logic      [PBC_DW-1:0]     look_data
);
    import pbc_pkg::*;

    typedef struct packed {
        logic [PBC_ATT_NUM-1:0][PBC_DW-1:0] entry;
        logic [PBC_DW-1:0]                  look;
    } pbc_att_s;

    pbc_att_s st;
    pbc_att_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.look = st.entry[look_idx];
        if (wr_en)
        begin
            next_st.entry[wr_idx] = (st.entry[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign rd_data   = st.entry[rd_idx];
    assign look_data = st.look;

endmodule : pbc_att_table

// >>> verilog/pbc_csr_bank.sv
/*
 * Control/status register bank of the bridge: 16 KB decode split into four
 * 4 KB sub-regions, interrupt status/enable for both sides, two mailbox
 * banks and the address translation table.
 * Assumes one clock, a synchronous active-high reset, and that all
 * requesters reach the port through one interconnect on the same clock.
 */
`timescale 1ns/10ps

// Contract
// - Every bridge register is reached only through this slave port.
// - Build option disables the bank; then no register can be accessed.
// - Decode a 16 KB space as four 4 KB sub-regions.
// - No check of which requester accesses which sub-region.
// - First sub-region: host enables, host-to-local mailboxes, local-to-host view.
// - Second sub-region holds the translation table, open to any requester.
// - Fourth sub-region: local enables, local-to-host mailboxes, host-to-local view.
// - Host interrupt status at 0x0040, enable at 0x0050.
// - Host-to-local mailboxes at 0x0800-0x081F, local-to-host view at 0x0900-0x091F.
// - Local interrupt status at 0x3060, enable at 0x3070.
// - Local-to-host mailboxes at 0x3A00-0x3A1F, host-to-local view at 0x3B00-0x3B1F.
// - Write to a host-to-local mailbox sets its local status bit.
module pbc_csr_bank
    import pbc_pkg::*;
#(
    parameter bit CRA_EN = 1'b1
)
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Register slave port
    input  wire logic                  csr_read,
    input  wire logic                  csr_write,
    input  wire logic [PBC_AW-1:0]     csr_addr,
    input  wire logic [PBC_DW-1:0]     csr_wdata,
    input  wire logic [3:0]            csr_byteen,
    output logic                       csr_ready,
    output logic                       csr_rvalid,
    output logic      [PBC_DW-1:0]     csr_rdata,
    // Local interrupt input from the bridge master side
    input  wire logic                  rxm_irq,
    input  wire logic [PBC_VEC_W-1:0]  rxm_irq_num,
    // Interrupt requests
    output logic                       host_irq_req,
    output logic                       local_irq_req,
    // Translation lookup
    input  wire logic [PBC_ATT_IW-1:0] att_lookup_idx,
    output logic      [PBC_DW-1:0]     att_lookup_data
);
    import pbc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pbc_bus_e             bus;
        logic                 ready;
        logic                 rvalid;
        logic [PBC_DW-1:0]    rdata;
        logic                 irq_lvl;
        logic [PBC_VEC_W-1:0] host_vec;
        logic [7:0]           host_mb;
        logic                 host_en_lvl;
        logic [7:0]           host_en_mb;
        logic [7:0]           local_mb;
        logic [7:0]           local_en_mb;
        logic                 host_irq;
        logic                 local_irq;
    } pbc_csr_s;

    pbc_csr_s st;
    pbc_csr_s next_st;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic              acc_ok;
    logic              wr_acc;
    logic              rd_acc;
    logic [1:0]        region;
    logic [PBC_DW-1:0] wmask;
    logic [PBC_DW-1:0] w1c;
    logic              hit_hst_stat;
    logic              hit_hst_en;
    logic              hit_h2l_wr;
    logic              hit_l2h_view;
    logic              hit_att;
    logic              hit_lcl_stat;
    logic              hit_lcl_en;
    logic              hit_l2h_wr;
    logic              hit_h2l_view;
    logic [PBC_DW-1:0] h2l_rd;
    logic [PBC_DW-1:0] l2h_rd;
    logic [PBC_DW-1:0] att_rd;
    logic [PBC_DW-1:0] host_stat_word;
    logic [PBC_DW-1:0] local_stat_word;

    // Word-aligned match against one register offset
    function automatic logic pbc_hit_word(input logic [13:0] a, input logic [13:0] off);
        pbc_hit_word = (a[13:2] == off[13:2]);
    endfunction : pbc_hit_word

    assign acc_ok = CRA_EN && st.ready;
    assign wr_acc = acc_ok && csr_write;
    assign rd_acc = acc_ok && csr_read && !csr_write;
    assign region = csr_addr[13:12];
    assign wmask  = pbc_be_mask(csr_byteen);
    assign w1c    = csr_wdata & wmask;

    // No requester identity enters any of these terms
    assign hit_hst_stat = pbc_hit_word(csr_addr, PBC_HOST_IRQ_STATUS);
    assign hit_hst_en   = pbc_hit_word(csr_addr, PBC_HOST_IRQ_ENABLE);
    assign hit_h2l_wr   = pbc_in_mbx(csr_addr, PBC_H2L_MBX_WRITE);
    assign hit_l2h_view = pbc_in_mbx(csr_addr, PBC_L2H_MBX_VIEW);
    assign hit_att      = (region == PBC_REG_ATT)
                          && (csr_addr[11:8] == PBC_ATT_BASE[11:8]);
    assign hit_lcl_stat = pbc_hit_word(csr_addr, PBC_LOCAL_IRQ_STATUS);
    assign hit_lcl_en   = pbc_hit_word(csr_addr, PBC_LOCAL_IRQ_ENABLE);
    assign hit_l2h_wr   = pbc_in_mbx(csr_addr, PBC_L2H_MBX_WRITE);
    assign hit_h2l_view = pbc_in_mbx(csr_addr, PBC_H2L_MBX_VIEW);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    pbc_mbx_bank u_h2l_mbx
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_acc && hit_h2l_wr),
        .wr_idx  (csr_addr[4:2]),
        .wr_data (csr_wdata),
        .wr_mask (wmask),
        .rd_idx  (csr_addr[4:2]),
        .rd_data (h2l_rd)
    );

    pbc_mbx_bank u_l2h_mbx
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_acc && hit_l2h_wr),
        .wr_idx  (csr_addr[4:2]),
        .wr_data (csr_wdata),
        .wr_mask (wmask),
        .rd_idx  (csr_addr[4:2]),
        .rd_data (l2h_rd)
    );

    pbc_att_table u_att
    (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .wr_en     (wr_acc && hit_att),
        .wr_idx    (csr_addr[7:2]),
        .wr_data   (csr_wdata),
        .wr_mask   (wmask),
        .rd_idx    (csr_addr[7:2]),
        .rd_data   (att_rd),
        .look_idx  (att_lookup_idx),
        .look_data (att_lookup_data)
    );

    // ------------------------------------------------------------
    // Status words as read
    // ------------------------------------------------------------
    always_comb
    begin
        host_stat_word = PBC_RST_WORD;
        host_stat_word[PBC_HOST_LVL_BIT] = st.irq_lvl;
        host_stat_word[PBC_HOST_VEC_LSB +: PBC_VEC_W] = st.host_vec;
        host_stat_word[PBC_HOST_MB_LSB +: 8] = st.host_mb;
        local_stat_word = PBC_RST_WORD;
        local_stat_word[PBC_LOCAL_MB_LSB +: 8] = st.local_mb;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st        = st;
        next_st.rvalid = 1'b0;
        next_st.ready  = 1'b1;
        next_st.bus    = PBC_BUS_IDLE;

        // Read: data taken at accept, returned next cycle
        if (rd_acc)
        begin
            next_st.bus    = PBC_BUS_RDATA;
            next_st.rvalid = 1'b1;
            next_st.ready  = 1'b0;
            next_st.rdata  = PBC_RST_WORD;
            if (hit_hst_stat)
            begin
                next_st.rdata = host_stat_word;
            end
            else if (hit_hst_en)
            begin
                next_st.rdata[PBC_HOST_LVL_BIT]    = st.host_en_lvl;
                next_st.rdata[PBC_HOST_MB_LSB +: 8] = st.host_en_mb;
            end
            else if (hit_h2l_wr || hit_h2l_view)
            begin
                next_st.rdata = h2l_rd;
            end
            else if (hit_l2h_wr || hit_l2h_view)
            begin
                next_st.rdata = l2h_rd;
            end
            else if (hit_att)
            begin
                next_st.rdata = att_rd;
            end
            else if (hit_lcl_stat)
            begin
                next_st.rdata = local_stat_word;
            end
            else if (hit_lcl_en)
            begin
                next_st.rdata[PBC_LOCAL_MB_LSB +: 8] = st.local_en_mb;
            end
        end
        else if (st.bus == PBC_BUS_RDATA)
        begin
            next_st.ready = 1'b1;
        end

        // Clears first so that a same-cycle set wins
        if (wr_acc && hit_hst_stat)
        begin
            next_st.host_vec = st.host_vec & ~w1c[PBC_HOST_VEC_LSB +: PBC_VEC_W];
            next_st.host_mb  = st.host_mb & ~w1c[PBC_HOST_MB_LSB +: 8];
        end
        if (wr_acc && hit_hst_en)
        begin
            if (wmask[PBC_HOST_LVL_BIT])
            begin
                next_st.host_en_lvl = csr_wdata[PBC_HOST_LVL_BIT];
            end
            if (csr_byteen[2])
            begin
                next_st.host_en_mb = csr_wdata[PBC_HOST_MB_LSB +: 8];
            end
        end
        if (wr_acc && hit_lcl_stat)
        begin
            next_st.local_mb = st.local_mb & ~w1c[PBC_LOCAL_MB_LSB +: 8];
        end
        if (wr_acc && hit_lcl_en && csr_byteen[0])
        begin
            next_st.local_en_mb = csr_wdata[PBC_LOCAL_MB_LSB +: 8];
        end

        // Event sets
        next_st.irq_lvl = rxm_irq;
        if (rxm_irq)
        begin
            next_st.host_vec = rxm_irq_num;
        end
        if (wr_acc && hit_l2h_wr)
        begin
            next_st.host_mb[csr_addr[4:2]] = 1'b1;
        end
        if (wr_acc && hit_h2l_wr)
        begin
            next_st.local_mb[csr_addr[4:2]] = 1'b1;
        end

        // Interrupt requests from registered status and enables
        next_st.host_irq  = (st.irq_lvl && st.host_en_lvl) || |(st.host_mb & st.host_en_mb);
        next_st.local_irq = |(st.local_mb & st.local_en_mb);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st             <= '0;
            st.bus         <= PBC_BUS_IDLE;
            st.ready       <= 1'b1;
            st.rdata       <= PBC_RST_WORD;
            st.host_vec    <= PBC_RST_VEC;
            st.host_mb     <= PBC_RST_MB;
            st.host_en_mb  <= PBC_RST_MB;
            st.local_mb    <= PBC_RST_MB;
            st.local_en_mb <= PBC_RST_MB;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign csr_ready     = st.ready;
    assign csr_rvalid    = st.rvalid;
    assign csr_rdata     = st.rdata;
    assign host_irq_req  = st.host_irq;
    assign local_irq_req = st.local_irq;

endmodule : pbc_csr_bank

// >>> sim/pbc_csr_sva.sv
/*
 * Port-level assertions for the bridge register bank, bound into every bank.
 * Assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/10ps

module pbc_csr_sva
    import pbc_pkg::*;
#(
    parameter bit CRA_EN = 1'b1
)
(
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  sys_rst,
    // Register port
    input wire logic                  csr_read,
    input wire logic                  csr_write,
    input wire logic [PBC_AW-1:0]     csr_addr,
    input wire logic [PBC_DW-1:0]     csr_wdata,
    input wire logic [3:0]            csr_byteen,
    input wire logic                  csr_ready,
    input wire logic                  csr_rvalid,
    input wire logic [PBC_DW-1:0]     csr_rdata,
    // Interrupts and lookup
    input wire logic                  rxm_irq,
    input wire logic [PBC_VEC_W-1:0]  rxm_irq_num,
    input wire logic                  host_irq_req,
    input wire logic                  local_irq_req,
    input wire logic [PBC_ATT_IW-1:0] att_lookup_idx,
    input wire logic [PBC_DW-1:0]     att_lookup_data
);
    wire logic rd_take = csr_read && !csr_write && csr_ready && CRA_EN;

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // Port handshake
    // ------------------------------------------------------------
    a_read_answer: assert property (rd_take |=> csr_rvalid && !csr_ready)
        else $error("read not answered one cycle later");
    a_rvalid_pulse: assert property (csr_rvalid |=> !csr_rvalid)
        else $error("read valid longer than one cycle");
    a_rvalid_cause: assert property (csr_rvalid |-> $past(rd_take))
        else $error("read valid without a taken read");
    a_ready_cause: assert property (!csr_ready |-> $past(rd_take))
        else $error("port busy without a taken read");
    a_write_quiet: assert property (csr_write && csr_ready |=> csr_ready && !csr_rvalid)
        else $error("write produced an answer or stall");
    a_rdata_hold: assert property (!csr_rvalid && !$past(sys_rst) |-> $stable(csr_rdata))
        else $error("read data moved without a read answer");
    a_bank_absent: assert property ((CRA_EN == 1'b0) |-> csr_ready && !csr_rvalid)
        else $error("absent bank answered a request");
    a_reset_quiet: assert property ($fell(sys_rst) |->
        !host_irq_req && !local_irq_req && csr_ready && csr_rdata == 32'h0000_0000)
        else $error("outputs not at reset values after reset");

    c_read: cover property (rd_take ##1 csr_rvalid);
    c_write: cover property (csr_write && csr_ready);
    c_host_irq: cover property ($rose(host_irq_req));
    c_local_irq: cover property ($rose(local_irq_req));
endmodule : pbc_csr_sva

bind pbc_csr_bank pbc_csr_sva #(.CRA_EN(CRA_EN)) pbc_csr_sva_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .csr_read(csr_read), .csr_write(csr_write),
    .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_byteen(csr_byteen),
    .csr_ready(csr_ready), .csr_rvalid(csr_rvalid), .csr_rdata(csr_rdata),
    .rxm_irq(rxm_irq), .rxm_irq_num(rxm_irq_num), .host_irq_req(host_irq_req),
    .local_irq_req(local_irq_req), .att_lookup_idx(att_lookup_idx),
    .att_lookup_data(att_lookup_data));

// >>> sim/pbc_irq_src.sv
/*
 * Model of the bridge master side that raises the local interrupt line.
 * Assumes the bench steers it with fire and vec on the falling edge.
 */
`timescale 1ns/10ps

module pbc_irq_src
    import pbc_pkg::*;
(
    // Clock
    input  wire logic                 ref_clk,
    // Control from the bench
    input  wire logic                 fire,
    input  wire logic [PBC_VEC_W-1:0] vec,
    // Lines into the bank
    output logic                      rxm_irq,
    output logic      [PBC_VEC_W-1:0] rxm_irq_num
);
    initial
    begin
        rxm_irq = 1'b0;
        rxm_irq_num = 6'h00;
    end

    // Vector is meaningless while idle, so it keeps changing
    always @(negedge ref_clk)
    begin
        rxm_irq <= fire;
        rxm_irq_num <= fire ? vec : ~rxm_irq_num;
    end
endmodule : pbc_irq_src

// >>> sim/test_pcie_bridge_csr_decoder.sv
/*
 * Self-checking bench for the bridge register bank: reset values, mailboxes,
 * status clearing, interrupts, translation table, reserved space.
 * Assumes the package, the bank, the checker and the source model.
 */
`timescale 1ns/10ps

module test_pcie_bridge_csr_decoder;
    import pbc_pkg::*;

    logic                  ref_clk    = 1'b0;
    logic                  sys_rst    = 1'b1;
    logic                  csr_read   = 1'b0;
    logic                  csr_write  = 1'b0;
    logic [PBC_AW-1:0]     csr_addr   = 14'h0000;
    logic [PBC_DW-1:0]     csr_wdata  = 32'h0000_0000;
    logic [3:0]            csr_byteen = 4'hF;
    logic                  fire       = 1'b0;
    logic [PBC_VEC_W-1:0]  vec        = 6'h00;
    logic [PBC_ATT_IW-1:0] att_idx    = 6'h00;
    logic                  csr_ready, csr_rvalid, off_ready, off_rvalid;
    logic                  rxm_irq, host_irq_req, local_irq_req;
    logic [PBC_VEC_W-1:0]  rxm_irq_num;
    logic [PBC_DW-1:0]     csr_rdata, att_lookup_data;
    int                    errors  = 0;
    int                    n_tests = 0;

    always #25 ref_clk = ~ref_clk;

    pbc_csr_bank #(.CRA_EN(1'b1)) pbc_csr_bank_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .csr_read(csr_read), .csr_write(csr_write),
        .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_byteen(csr_byteen),
        .csr_ready(csr_ready), .csr_rvalid(csr_rvalid), .csr_rdata(csr_rdata),
        .rxm_irq(rxm_irq), .rxm_irq_num(rxm_irq_num), .host_irq_req(host_irq_req),
        .local_irq_req(local_irq_req), .att_lookup_idx(att_idx),
        .att_lookup_data(att_lookup_data));

    pbc_csr_bank #(.CRA_EN(1'b0)) pbc_csr_bank_off_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .csr_read(csr_read), .csr_write(csr_write),
        .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_byteen(csr_byteen),
        .csr_ready(off_ready), .csr_rvalid(off_rvalid), .csr_rdata(),
        .rxm_irq(rxm_irq), .rxm_irq_num(rxm_irq_num), .host_irq_req(),
        .local_irq_req(), .att_lookup_idx(att_idx), .att_lookup_data());

    pbc_irq_src pbc_irq_src_i (
        .ref_clk(ref_clk), .fire(fire), .vec(vec),
        .rxm_irq(rxm_irq), .rxm_irq_num(rxm_irq_num));

    // ------------------------------------------------------------
    // Port tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] be);
        @(negedge ref_clk);
        csr_write = 1'b1;
        csr_addr = a;
        csr_wdata = d;
        csr_byteen = be;
        while (csr_ready !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        @(negedge ref_clk);
        csr_write = 1'b0;
    endtask : wr

    task automatic rd(input logic [13:0] a, input logic [31:0] exp);
        @(negedge ref_clk);
        csr_read = 1'b1;
        csr_addr = a;
        while (csr_ready !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        @(negedge ref_clk);
        csr_read = 1'b0;
        chk({31'h0, csr_rvalid}, 32'h0000_0001);
        chk(csr_rdata, exp);
        chk({30'h0, off_ready, off_rvalid}, 32'h0000_0002);
    endtask : rd

    task automatic results;
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        rd(PBC_HOST_IRQ_STATUS, 32'h0);
        rd(PBC_HOST_IRQ_ENABLE, 32'h0);
        rd(PBC_LOCAL_IRQ_STATUS, 32'h0);
        rd(PBC_LOCAL_IRQ_ENABLE, 32'h0);
        // Both mailbox banks; writes to the views are dropped
        for (int k = 0; k < 8; k++)
        begin
            wr(PBC_H2L_MBX_WRITE + 14'(4 * k), 32'hC0DE_0000 + 32'(k), 4'hF);
            wr(PBC_L2H_MBX_WRITE + 14'(4 * k), 32'h5A5A_0000 + 32'(k), 4'hF);
            wr(PBC_H2L_MBX_VIEW + 14'(4 * k), 32'hFFFF_FFFF, 4'hF);
            wr(PBC_L2H_MBX_VIEW + 14'(4 * k), 32'hFFFF_FFFF, 4'hF);
        end
        for (int k = 0; k < 8; k++)
        begin
            rd(PBC_H2L_MBX_WRITE + 14'(4 * k), 32'hC0DE_0000 + 32'(k));
            rd(PBC_H2L_MBX_VIEW + 14'(4 * k), 32'hC0DE_0000 + 32'(k));
            rd(PBC_L2H_MBX_WRITE + 14'(4 * k), 32'h5A5A_0000 + 32'(k));
            rd(PBC_L2H_MBX_VIEW + 14'(4 * k), 32'h5A5A_0000 + 32'(k));
        end
        rd(PBC_LOCAL_IRQ_STATUS, 32'h0000_00FF);
        rd(PBC_HOST_IRQ_STATUS, 32'h00FF_0000);
        wr(PBC_H2L_MBX_WRITE, 32'h1234_5678, 4'h1);
        rd(PBC_H2L_MBX_VIEW, 32'hC0DE_0078);
        // Clear all but one local bit, then raise and drop the local request
        wr(PBC_LOCAL_IRQ_STATUS, 32'h0000_00FE, 4'hF);
        rd(PBC_LOCAL_IRQ_STATUS, 32'h0000_0001);
        wr(PBC_LOCAL_IRQ_ENABLE, 32'h0000_0001, 4'hF);
        repeat (3) @(negedge ref_clk);
        chk({31'h0, local_irq_req}, 32'h0000_0001);
        wr(PBC_LOCAL_IRQ_STATUS, 32'h0000_0001, 4'hF);
        repeat (3) @(negedge ref_clk);
        chk({31'h0, local_irq_req}, 32'h0000_0000);
        wr(PBC_HOST_IRQ_STATUS, 32'h00FF_0000, 4'hF);
        // Bridge interrupt line with a vector
        fire <= 1'b1;
        vec <= 6'h2A;
        repeat (4) @(negedge ref_clk);
        rd(PBC_HOST_IRQ_STATUS, 32'h0000_2A80);
        wr(PBC_HOST_IRQ_ENABLE, 32'h0000_0080, 4'hF);
        repeat (3) @(negedge ref_clk);
        chk({31'h0, host_irq_req}, 32'h0000_0001);
        fire <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk({31'h0, host_irq_req}, 32'h0000_0000);
        rd(PBC_HOST_IRQ_STATUS, 32'h0000_2A00);
        wr(PBC_HOST_IRQ_STATUS, 32'h0000_3F00, 4'h2);
        rd(PBC_HOST_IRQ_STATUS, 32'h0);
        rd(PBC_HOST_IRQ_ENABLE, 32'h0000_0080);
        // Translation table ends and lookup port
        wr(PBC_ATT_BASE, 32'hA5A5_0001, 4'hF);
        wr(PBC_ATT_BASE + 14'h00FC, 32'hA5A5_003F, 4'hF);
        rd(PBC_ATT_BASE, 32'hA5A5_0001);
        rd(PBC_ATT_BASE + 14'h00FC, 32'hA5A5_003F);
        att_idx = 6'h3F;
        repeat (2) @(negedge ref_clk);
        chk(att_lookup_data, 32'hA5A5_003F);
        // Reserved and undefined places swallow writes
        wr(14'h2000, 32'hFFFF_FFFF, 4'hF);
        wr(14'h1100, 32'hFFFF_FFFF, 4'hF);
        wr(14'h0044, 32'hFFFF_FFFF, 4'hF);
        rd(14'h2000, 32'h0);
        rd(14'h1100, 32'h0);
        rd(14'h0044, 32'h0);
        rd(PBC_HOST_IRQ_ENABLE, 32'h0000_0080);
        rd(PBC_LOCAL_IRQ_STATUS, 32'h0);
        results();
    end

    initial
    begin
        #100000;
        errors++;
        results();
    end
endmodule : test_pcie_bridge_csr_decoder
